// ===== crab_access.v
// host access decode and readback for three 16-bit interval counters
`include "crab_consts.vh"

// Notes on behaviour
// - read/load field 00 latch, 01 low only, 10 high only, 11 low then high.
// - with 11 a count moves as two byte accesses, low first, flip-flop tracks.
// - control byte with read/load 00 copies present count into hold register.
// - next read after latch returns held value, counting continues.
// - without a latch, reads return the live counting element.
// - select field 00/01/10 picks counter 0/1/2, 11 means readback.
// - readback byte: 11, latch_n, report_n, picks 2..0, zero in bit 0.
// - each pick bit selects its counter independently.
// - latch request low latches all picked counters together.
// - report request low makes next read return the status byte.
// - status holds output, null flag, then read/load, config, decimal bits.
// - status bit 7 is the present output level.
// - null flag shows written count not yet moved into the element.
// - control byte: select(2), read/load(2), config(3), decimal select.
// - decimal bit 0 binary to 65,535, 1 four decades to 9,999.
module crab_access #(
  parameter NUM_CNT = 3
) (
  input  wire                  sys_clk,
  input  wire                  reset,
  input  wire                  clk_en,
  input  wire [1:0]            addr,
  input  wire                  wr_stb,
  input  wire                  rd_stb,
  input  wire [7:0]            wr_data,
  output reg  [7:0]            rd_data_r,
  input  wire [16*NUM_CNT-1:0] live_count,
  input  wire [NUM_CNT-1:0]    out_level,
  input  wire [NUM_CNT-1:0]    count_moved,
  output wire [16*NUM_CNT-1:0] load_value,
  output wire [NUM_CNT-1:0]    load_stb,
  output wire [6*NUM_CNT-1:0]  counter_cfg
);

  // =====================================================================
  // control byte decode
  wire       ctrl_wr;
  wire [1:0] sel;
  wire [1:0] rl;
  wire       readback;
  wire       rb_valid;
  wire       latch_request_n;
  wire       report_request_n;
  wire [2:0] pick;

  assign ctrl_wr          = wr_stb && (addr == `CRAB_ADDR_CTRL);
  assign sel              = wr_data[`CRAB_SEL_HI:`CRAB_SEL_LO];
  assign rl               = wr_data[`CRAB_RL_HI:`CRAB_RL_LO];
  assign readback         = (sel == `CRAB_SEL_READBACK);
  // a readback byte with bit 0 set is ignored
  assign rb_valid         = readback && !wr_data[`CRAB_RB_ZERO];
  assign latch_request_n  = wr_data[`CRAB_RB_LATCH_N];
  assign report_request_n = wr_data[`CRAB_RB_REPORT_N];
  assign pick             = wr_data[`CRAB_RB_PICK_LO+2:`CRAB_RB_PICK_LO];

  // =====================================================================
  // read byte of the addressed counter
  wire [8*NUM_CNT-1:0] chan_byte;
  reg  [7:0]           rd_nxt;

  always @* begin
    rd_nxt = `CRAB_UNMAPPED_RD;
    if (addr != `CRAB_ADDR_CTRL) begin
      rd_nxt = chan_byte[8*addr +: 8];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      rd_data_r <= 8'h00;
    end else if (clk_en && rd_stb) begin
      rd_data_r <= rd_nxt;
    end
  end

  // =====================================================================
  // per counter access channels
  genvar i;
  generate
    for (i = 0; i < NUM_CNT; i = i + 1) begin : g_chan
      localparam integer CH_NUM = i;
      localparam [1:0]   CH_IDX = CH_NUM[1:0];
      wire hit;
      wire ctl_sel;
      wire latch_cmd;
      wire report_cmd;

      assign hit        = (addr == CH_IDX);
      assign ctl_sel    = ctrl_wr && !readback && (sel == CH_IDX);
      // single latch or simultaneous readback latch
      assign latch_cmd  = (ctl_sel && (rl == `CRAB_RL_LATCH)) ||
                          (ctrl_wr && rb_valid && pick[i] && !latch_request_n);
      assign report_cmd = ctrl_wr && rb_valid && pick[i] && !report_request_n;

      crab_chan u_chan (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .clk_en       (clk_en),
        .ctl_wr       (ctl_sel && (rl != `CRAB_RL_LATCH)),
        .ctl_cfg      (wr_data[`CRAB_CFG_HI:`CRAB_CFG_LO]),
        .latch_cmd    (latch_cmd),
        .report_cmd   (report_cmd),
        .data_wr      (wr_stb && hit),
        .data_rd      (rd_stb && hit),
        .wr_data      (wr_data),
        .live_count   (live_count[16*i +: 16]),
        .out_level    (out_level[i]),
        .count_moved  (count_moved[i]),
        .rd_byte      (chan_byte[8*i +: 8]),
        .cfg_r        (counter_cfg[6*i +: 6]),
        .load_value_r (load_value[16*i +: 16]),
        .load_stb_r   (load_stb[i])
      );
    end
  endgenerate

endmodule

// ===== crab_access_assertions.sv
// port checker for the counter access block
module crab_access_chk #(parameter NUM_CNT = 3) (
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  input wire [1:0] addr,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data_r,
  input wire [16*NUM_CNT-1:0] live_count,
  input wire [NUM_CNT-1:0] out_level,
  input wire [NUM_CNT-1:0] count_moved,
  input wire [16*NUM_CNT-1:0] load_value,
  input wire [NUM_CNT-1:0] load_stb,
  input wire [6*NUM_CNT-1:0] counter_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire cw = clk_en && wr_stb && addr == 2'h3;
  wire [1:0] rl0 = counter_cfg[5:4];
  property p_rd_keep; !(clk_en && rd_stb) |=> $stable(rd_data_r); endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read data moved");
  property p_ctl_rd; clk_en && rd_stb && addr == 2'h3 |=> rd_data_r == 8'h00; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read not zero");
  property p_cfg_wr;
    cw && wr_data[7:6] == 2'h0 && wr_data[5:4] != 2'h0 |=> counter_cfg[5:0] == $past(wr_data[5:0]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("settings not taken");
  property p_cfg_keep; !cw |=> $stable(counter_cfg); endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("settings moved");
  property p_sel_rb; cw && wr_data[7:6] == 2'h3 |=> $stable(counter_cfg); endproperty
  a_sel_rb: assert property (p_sel_rb) else $error("readback changed settings");
  property p_ld_src; load_stb[0] |-> $past(clk_en && wr_stb && addr == 2'h0); endproperty
  a_ld_src: assert property (p_ld_src) else $error("load without write");
  property p_ld_low;
    load_stb[0] && rl0 == 2'h1 |-> load_value[15:0] == {8'h00, $past(wr_data)};
  endproperty
  a_ld_low: assert property (p_ld_low) else $error("low only load wrong");
  property p_ld_high;
    load_stb[0] && rl0 == 2'h2 |-> load_value[15:0] == {$past(wr_data), 8'h00};
  endproperty
  a_ld_high: assert property (p_ld_high) else $error("high only load wrong");
  property p_ld_pair; load_stb[0] && rl0 == 2'h3 |-> load_value[15:8] == $past(wr_data); endproperty
  a_ld_pair: assert property (p_ld_pair) else $error("pair high byte wrong");
  c_load: cover property (load_stb[0]);
  c_ctl_rd: cover property (clk_en && rd_stb && addr == 2'h3);
  c_rb: cover property (cw && wr_data[7:6] == 2'h3);
endmodule
bind crab_access crab_access_chk #(.NUM_CNT(NUM_CNT)) u_chk (.sys_clk(sys_clk), .reset(reset),
  .clk_en(clk_en), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
  .rd_data_r(rd_data_r), .live_count(live_count), .out_level(out_level),
  .count_moved(count_moved), .load_value(load_value), .load_stb(load_stb),
  .counter_cfg(counter_cfg));

// ===== crab_access_test.sv
// self-checking bench for the counter access block
module crab_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg clk_en = 1'b1;
  reg run = 1'b0;
  reg [1:0] addr = 2'h0;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg [7:0] wr_data = 8'h00;
  wire [7:0] rd_data_r;
  wire [47:0] live_count;
  wire [47:0] load_value;
  wire [2:0] out_level;
  wire [2:0] count_moved;
  wire [2:0] load_stb;
  wire [17:0] counter_cfg;
  reg [7:0] b;
  reg [47:0] snap;
  reg [47:0] hold;
  reg [15:0] w;
  integer err_count = 0;
  integer tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  crab_access #(.NUM_CNT(3)) DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data_r(rd_data_r),
    .live_count(live_count), .out_level(out_level), .count_moved(count_moved),
    .load_value(load_value), .load_stb(load_stb), .counter_cfg(counter_cfg));
  crab_cnt_model u_cnt (.sys_clk(sys_clk), .reset(reset), .run(run), .load_value(load_value),
    .load_stb(load_stb), .live_count(live_count), .out_level(out_level),
    .count_moved(count_moved));
  // ====
  // bus tasks
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wr_data = d;
    wr_stb = 1'b1;
    snap = live_count;
    @(negedge sys_clk);
    wr_stb = 1'b0;
  endtask
  task rd(input [1:0] a);
    @(negedge sys_clk);
    addr = a;
    rd_stb = 1'b1;
    @(negedge sys_clk);
    rd_stb = 1'b0;
    @(negedge sys_clk);
    b = rd_data_r;
  endtask
  task rd16(input [1:0] a);
    rd(a);
    w[7:0] = b;
    rd(a);
    w[15:8] = b;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ====
  // scenarios
  task t_load;
    wr(2'h3, 8'h34);
    chk("cfg0", counter_cfg[5:0], 16'h0034);
    wr(2'h3, 8'hE2);
    rd(2'h0);
    chk("status new", b, 16'h0074);
    wr(2'h0, 8'h10);
    wr(2'h0, 8'h27);
    chk("load strobe", load_stb, 16'h0001);
    @(negedge sys_clk);
    chk("pair load", load_value[15:0], 16'h2710);
    chk("strobe one cycle", load_stb, 16'h0000);
    wr(2'h3, 8'hE2);
    rd(2'h0);
    chk("status moved", b, 16'h0034);
    rd16(2'h0);
    chk("live read", w, 16'h2710);
    wr(2'h3, 8'h10);
    wr(2'h0, 8'h5A);
    @(negedge sys_clk);
    chk("low only", load_value[15:0], 16'h005A);
    wr(2'h3, 8'h20);
    wr(2'h0, 8'h3C);
    @(negedge sys_clk);
    chk("high only", load_value[15:0], 16'h3C00);
    $display("t_load done");
  endtask
  task t_latch;
    wr(2'h3, 8'h34);
    run = 1'b1;
    wr(2'h3, 8'h00);
    hold = snap;
    wr(2'h3, 8'h00);
    rd16(2'h0);
    chk("held count", w, hold[15:0]);
    chk("still counting", live_count[15:0] != hold[15:0], 16'h0001);
    $display("t_latch done");
  endtask
  task t_rb;
    wr(2'h3, 8'h74);
    wr(2'h3, 8'hB4);
    wr(2'h3, 8'hDC);
    hold = snap;
    rd16(2'h1);
    chk("rb ctr1", w, hold[31:16]);
    rd16(2'h2);
    chk("rb ctr2", w, hold[47:32]);
    rd(2'h3);
    chk("ctl read", b, 16'h0000);
    wr(2'h3, 8'hE4);
    rd(2'h1);
    chk("status out high", b, 16'h00F4);
    run = 1'b0;
    wr(2'h3, 8'hE3);
    rd16(2'h0);
    chk("bad rb ignored", w, live_count[15:0]);
    $display("t_rb done");
  endtask
  task t_freeze;
    reg [7:0] last;
    last = rd_data_r;
    @(negedge sys_clk);
    clk_en = 1'b0;
    wr(2'h3, 8'h10);
    rd(2'h0);
    chk("frozen cfg", counter_cfg[5:0], 16'h0034);
    chk("frozen read", b, last);
    @(negedge sys_clk);
    clk_en = 1'b1;
    $display("t_freeze done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    t_load;
    t_latch;
    t_rb;
    t_freeze;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count = err_count + 1;
    close_out;
  end
endmodule

// ===== crab_chan.v
// access logic of one counter: settings, byte order, hold and status
`include "crab_consts.vh"

module crab_chan (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        ctl_wr,
  input  wire [5:0]  ctl_cfg,
  input  wire        latch_cmd,
  input  wire        report_cmd,
  input  wire        data_wr,
  input  wire        data_rd,
  input  wire [7:0]  wr_data,
  input  wire [15:0] live_count,
  input  wire        out_level,
  input  wire        count_moved,
  output wire [7:0]  rd_byte,
  output reg  [5:0]  cfg_r,
  output reg  [15:0] load_value_r,
  output reg         load_stb_r
);

  reg  [15:0] hold_r;
  reg         held_r;
  reg  [7:0]  stat_r;
  reg         stat_held_r;
  reg         wr_high_r;
  reg         rd_high_r;
  reg         null_r;
  wire [1:0]  rl;
  wire [15:0] src;
  wire        pick_high;

  assign rl        = cfg_r[`CRAB_CFG_HI:`CRAB_RL_LO];
  // held copy or live element
  assign src       = held_r ? hold_r : live_count;
  assign pick_high = (rl == `CRAB_RL_HIGH) || ((rl == `CRAB_RL_PAIR) && rd_high_r);
  assign rd_byte   = stat_held_r ? stat_r : (pick_high ? src[15:8] : src[7:0]);

  // =====================================================================
  // settings, byte order, latches
  always @(posedge sys_clk) begin
    if (reset) begin
      cfg_r        <= `CRAB_CFG_RESET;
      hold_r       <= 16'h0000;
      held_r       <= 1'b0;
      stat_r       <= 8'h00;
      stat_held_r  <= 1'b0;
      wr_high_r    <= 1'b0;
      rd_high_r    <= 1'b0;
      null_r       <= 1'b0;
      load_value_r <= 16'h0000;
      load_stb_r   <= 1'b0;
    end else if (clk_en) begin
      load_stb_r <= 1'b0;
      if (ctl_wr) begin
        cfg_r     <= ctl_cfg;
        wr_high_r <= 1'b0;
        rd_high_r <= 1'b0;
        held_r    <= 1'b0;
      end
      if (latch_cmd && !held_r) begin
        hold_r <= live_count;
        held_r <= 1'b1;
      end
      if (report_cmd && !stat_held_r) begin
        stat_r      <= {out_level, null_r, cfg_r};
        stat_held_r <= 1'b1;
      end
      if (data_wr) begin
        case (rl)
          `CRAB_RL_LOW: begin
            load_value_r <= {8'h00, wr_data};
            load_stb_r   <= 1'b1;
          end
          `CRAB_RL_HIGH: begin
            load_value_r <= {wr_data, 8'h00};
            load_stb_r   <= 1'b1;
          end
          `CRAB_RL_PAIR: begin
            if (wr_high_r) begin
              load_value_r[15:8] <= wr_data;
              load_stb_r         <= 1'b1;
            end else begin
              load_value_r[7:0] <= wr_data;
            end
            wr_high_r <= ~wr_high_r;
          end
          default: begin
            load_stb_r <= 1'b0;
          end
        endcase
      end
      if (data_rd) begin
        if (stat_held_r) begin
          stat_held_r <= 1'b0;
        end else if (rl == `CRAB_RL_PAIR) begin
          rd_high_r <= ~rd_high_r;
          if (rd_high_r) begin
            held_r <= 1'b0;
          end
        end else begin
          held_r <= 1'b0;
        end
      end
      // a new count outranks the transfer report
      if (ctl_wr || load_stb_r) begin
        null_r <= 1'b1;
      end else if (count_moved) begin
        null_r <= 1'b0;
      end
    end
  end

endmodule

// ===== crab_cnt_model.sv
// counting element model behind the access block
module crab_cnt_model (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        run,
  input  wire [47:0] load_value,
  input  wire [2:0]  load_stb,
  output reg  [47:0] live_count,
  output wire [2:0]  out_level,
  output reg  [2:0]  count_moved
);
  timeunit 1ns;
  timeprecision 1ps;
  integer i;
  assign out_level = {live_count[47], live_count[31], live_count[15]};
  always @(posedge sys_clk) begin
    for (i = 0; i < 3; i = i + 1) begin
      count_moved[i] <= load_stb[i] & ~reset;
      if (reset)
        live_count[16*i +: 16] <= 16'h0000;
      else if (load_stb[i])
        live_count[16*i +: 16] <= load_value[16*i +: 16];
      else if (run)
        live_count[16*i +: 16] <= live_count[16*i +: 16] - 16'h0001;
    end
  end
endmodule

// ===== crab_consts.vh
// constants for the counter access and readback block
`ifndef CRAB_CONSTS_VH
`define CRAB_CONSTS_VH
// =====================================================================
// i/o locations on the 2-bit address
`define CRAB_ADDR_CNT0    2'h0
`define CRAB_ADDR_CNT1    2'h1
`define CRAB_ADDR_CNT2    2'h2
`define CRAB_ADDR_CTRL    2'h3
// =====================================================================
// control byte fields
`define CRAB_SEL_HI       7
`define CRAB_SEL_LO       6
`define CRAB_RL_HI        5
`define CRAB_RL_LO        4
`define CRAB_CFG_HI       5
`define CRAB_CFG_LO       0
`define CRAB_DEC_BIT      0
// =====================================================================
// read/load codes and the readback select code
`define CRAB_RL_LATCH     2'h0
`define CRAB_RL_LOW       2'h1
`define CRAB_RL_HIGH      2'h2
`define CRAB_RL_PAIR      2'h3
`define CRAB_SEL_READBACK 2'h3
// =====================================================================
// readback command fields
`define CRAB_RB_LATCH_N   5
`define CRAB_RB_REPORT_N  4
`define CRAB_RB_PICK_LO   1
`define CRAB_RB_ZERO      0
// =====================================================================
// status byte fields and reset values
`define CRAB_ST_OUT       7
`define CRAB_ST_NULL      6
`define CRAB_CFG_RESET    6'h00
`define CRAB_UNMAPPED_RD  8'h00
`endif
